// ==== verilog/local_bus_cycle_control.sv ====
`default_nettype none
module local_bus_cycle_control
   import cycle_ctl_pkg::*;
(
   input wire logic mclk, // Clock, 40 MHz.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic hold_ack, // CPU hold acknowledge, high when another master owns the bus.
   input wire logic dma_bus_grant_in_n, // DMA or ISA master grant, active low.
   input wire logic isa_master_n, // ISA master owns the bus, active low.
   input wire logic cpu_type, // Selects how the SMM indicator is read.
   input wire logic smm_cycle_indicator_n, // SMM status or SMM address strobe, active low.
   input wire logic [addr_w-1:0] cycle_addr, // Address of the current local-bus cycle.
   input wire logic dram_hit, // Current address decodes to local DRAM.
   input wire logic slave_select, // This block is the addressed slave.
   input wire logic burst_req, // Slave access wants burst ready.
   input wire logic [addr_w-1:0] nc_base [nc_regions], // Non-cacheable window bases.
   input wire logic [addr_w-1:0] nc_limit [nc_regions], // Non-cacheable window limits.
   input wire logic [nc_regions-1:0] nc_enable, // Non-cacheable window enables.
   input wire logic alt_cycle_start, // Request a DMA or ISA-master local cycle.
   input wire logic alt_write, // Write for the alternate cycle.
   input wire logic alt_data, // Data (not code) for the alternate cycle.
   input wire logic alt_mem, // Memory (not IO) for the alternate cycle.
   input wire logic ads_in_n, // Address strobe pin input.
   output logic ads_out_n, // Address strobe pin output.
   output logic ads_oe, // Address strobe output enable.
   input wire logic [2:0] status_in, // Status pins in: {write, data, mem}.
   output logic [2:0] status_out, // Status pins out.
   output logic status_oe, // Status output enable.
   input wire logic rdy_in_n, // Non-burst ready pin input.
   output logic rdy_out_n, // Non-burst ready pin output.
   output logic rdy_oe, // Non-burst ready output enable.
   input wire logic brdy_in_n, // Burst ready pin input.
   output logic brdy_out_n, // Burst ready pin output.
   output logic brdy_oe, // Burst ready output enable.
   output logic cache_en_n, // Cache enable to the CPU, always driven.
   output logic cpu_cycle_start, // One-cycle pulse: CPU or local master started a cycle.
   output logic [2:0] cpu_cycle_status, // Status captured with that cycle.
   output logic smm_active, // SMM in effect for the current cycle.
   output logic cycle_ready, // One-cycle pulse: ready seen on the bus.
   output logic alt_is_isa, // Alternate cycle belongs to an ISA master.
   output logic alt_busy // Sequencer busy: alternate cycle or CPU slave cycle in progress.
);
   logic cpu_owns;
   logic alt_owns;
   logic [nc_regions-1:0] nc_hit;
   cyc_state_t st_q, st_d;
   logic [3:0] wait_q, wait_d;
   logic [2:0] stat_q, stat_d;
   logic isa_q, isa_d;
   logic smm_q, smm_d;
   logic ken_q, ken_d;
   logic [2:0] cap_q, cap_d;
   logic start_q, start_d;
   logic srdy_q, srdy_d;
   logic sbrdy_q, sbrdy_d;
   logic rdy_q, rdy_d;

   // Hold acknowledge alone hands the bus away; DMA and ISA masters also need the grant.
   assign cpu_owns = !hold_ack;
   assign alt_owns = hold_ack && !dma_bus_grant_in_n;

   for (genvar i = 0; i < nc_regions; i++) begin : g_nc
      nc_window u_win (
         .addr(cycle_addr),
         .base(nc_base[i]),
         .limit(nc_limit[i]),
         .enable(nc_enable[i]),
         .hit(nc_hit[i])
      );
   end

   // Alternate-master cycle sequencer and slave-ready timing.
   always_comb begin
      st_d = st_q;
      wait_d = wait_q;
      stat_d = stat_q;
      isa_d = isa_q;
      srdy_d = 1'b0;
      sbrdy_d = 1'b0;
      // One countdown paces our ready for DMA, ISA-master and CPU slave cycles alike.
      unique case (st_q)
         st_idle: begin
            if (alt_owns && alt_cycle_start) begin
               st_d = st_addr;
               stat_d = {alt_write, alt_data, alt_mem};
               isa_d = !isa_master_n;
            end else if (slave_select && cpu_owns && !ads_in_n) begin
               st_d = st_wait;
               wait_d = ready_wait_cycles;
            end
         end
         st_addr: begin
            st_d = st_wait;
            wait_d = ready_wait_cycles;
         end
         st_wait: begin
            if (wait_q != 4'h0) begin
               wait_d = wait_q - 4'h1;
            end else begin
               st_d = st_done;
               srdy_d = slave_select && !burst_req;
               sbrdy_d = slave_select && burst_req;
            end
         end
         st_done: begin
            st_d = st_idle;
         end
         default: begin
            st_d = st_idle;
         end
      endcase
      // Losing the grant before the strobe has gone out abandons the cycle cleanly.
      if (!alt_owns && st_q == st_addr) begin
         st_d = st_idle;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q <= st_idle;
         wait_q <= 4'h0;
         stat_q <= 3'h0;
         isa_q <= 1'b0;
         srdy_q <= 1'b0;
         sbrdy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         wait_q <= wait_d;
         stat_q <= stat_d;
         isa_q <= isa_d;
         srdy_q <= srdy_d;
         sbrdy_q <= sbrdy_d;
      end
   end

   // Pin direction: the CPU side floats these while we drive them.
   assign ads_oe = alt_owns;
   assign ads_out_n = !(st_q == st_addr);
   assign status_oe = alt_owns;
   assign status_out = stat_q;
   // Ready lines are driven only for the cycle they are asserted, so a
   // neighbouring slave is never fought outside our own data phase.
   assign rdy_oe = srdy_q;
   assign rdy_out_n = !srdy_q;
   assign brdy_oe = sbrdy_q;
   assign brdy_out_n = !sbrdy_q;

   // A strobe that we did not drive starts a CPU or local-master cycle.
   always_comb begin
      start_d = !alt_owns && !ads_in_n;
      cap_d = cap_q;
      if (start_d) begin
         cap_d = status_in;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         start_q <= 1'b0;
         cap_q <= 3'h0;
      end else begin
         start_q <= start_d;
         cap_q <= cap_d;
      end
   end

   // SMM decode. In strobe mode the flag lasts until the next plain strobe; a marker on the
   // same edge as a plain strobe wins, so an SMM cycle is never reported as a normal one.
   always_comb begin
      smm_d = smm_q;
      if (cpu_type == cpu_type_level) begin
         smm_d = !smm_cycle_indicator_n;
      end else if (!smm_cycle_indicator_n) begin
         smm_d = 1'b1;
      end else if (start_d) begin
         smm_d = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         smm_q <= 1'b0;
      end else begin
         smm_q <= smm_d;
      end
   end

   // Only CPU accesses fill the CPU cache, so an alternate master never sees cache enable.
   always_comb begin
      ken_d = dram_hit && (nc_hit == '0) && cpu_owns;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ken_q <= 1'b0;
      end else begin
         ken_q <= ken_d;
      end
   end

   // Ready seen on the bus, our own or another slave's, as a one-cycle pulse.
   always_comb begin
      rdy_d = (!rdy_in_n && !srdy_q) || (!brdy_in_n && !sbrdy_q) || srdy_q || sbrdy_q;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdy_q <= 1'b0;
      end else begin
         rdy_q <= rdy_d;
      end
   end

   assign cache_en_n = !ken_q;
   assign cpu_cycle_start = start_q;
   assign cpu_cycle_status = cap_q;
   assign smm_active = smm_q;
   assign cycle_ready = rdy_q;
   assign alt_is_isa = isa_q;
   assign alt_busy = (st_q != st_idle);
endmodule : local_bus_cycle_control
`default_nettype wire

// ==== verilog/cycle_ctl_pkg.sv ====
`default_nettype none
package cycle_ctl_pkg;
   localparam int addr_w = 32;
   localparam int nc_regions = 2;
   localparam logic cpu_type_level = 1'b0;
   localparam logic cpu_type_strobe = 1'b1;
   localparam logic [3:0] ready_wait_cycles = 4'h2;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_addr = 2'b01,
      st_wait = 2'b11,
      st_done = 2'b10
   } cyc_state_t;
endpackage : cycle_ctl_pkg
`default_nettype wire

// ==== verilog/nc_window.sv ====
`default_nettype none
module nc_window
   import cycle_ctl_pkg::*;
(
   input wire logic [addr_w-1:0] addr, // Cycle address.
   input wire logic [addr_w-1:0] base, // Window base.
   input wire logic [addr_w-1:0] limit, // Window last address.
   input wire logic enable, // Window in use.
   output logic hit // Address inside window.
);
   assign hit = enable && (addr >= base) && (addr <= limit);
endmodule : nc_window
`default_nettype wire

// ==== testbench/cycle_ctl_checker.sv ====
`default_nettype none
module cycle_ctl_checker
   import cycle_ctl_pkg::*;
(
   input wire logic mclk, // Clock.
   input wire logic reset, // Reset.
   input wire logic hold_ack, // Owner.
   input wire logic dma_bus_grant_in_n, // Grant.
   input wire logic cpu_type, // Mode.
   input wire logic smm_cycle_indicator_n, // SMM pin.
   input wire logic dram_hit, // Decode.
   input wire logic slave_select, // Decode.
   input wire logic burst_req, // Decode.
   input wire logic [nc_regions-1:0] nc_enable, // Windows.
   input wire logic ads_in_n, // Pin.
   input wire logic ads_out_n, // Pin.
   input wire logic ads_oe, // Pin.
   input wire logic [2:0] status_in, // Pins.
   input wire logic status_oe, // Pins.
   input wire logic rdy_out_n, // Pin.
   input wire logic rdy_oe, // Pin.
   input wire logic brdy_out_n, // Pin.
   input wire logic brdy_oe, // Pin.
   input wire logic cache_en_n, // Pin.
   input wire logic cpu_cycle_start, // Pulse.
   input wire logic [2:0] cpu_cycle_status, // Status.
   input wire logic smm_active // Level.
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   chk_ads_owner: assert property (ads_oe == (hold_ack && !dma_bus_grant_in_n))
      else $error("Strobe direction wrong.");
   chk_status_dir: assert property (status_oe == ads_oe)
      else $error("Status direction wrong.");
   chk_rdy_after_ads: assert property ($fell(ads_out_n) && slave_select && !burst_req |-> ##4 rdy_oe && !rdy_out_n)
      else $error("Ready late or missing.");
   chk_brdy_after_ads: assert property ($fell(ads_out_n) && slave_select && burst_req |-> ##4 brdy_oe && !brdy_out_n)
      else $error("Burst ready late or missing.");
   chk_ken_off: assert property (!dram_hit |=> cache_en_n)
      else $error("Cache enable off DRAM.");
   chk_ken_on: assert property (dram_hit && !hold_ack && nc_enable == 2'h0 |=> !cache_en_n)
      else $error("Cache enable missing.");
   chk_smm_level: assert property (cpu_type == cpu_type_level |=> smm_active == !$past(smm_cycle_indicator_n))
      else $error("SMM level wrong.");
   chk_smm_strobe: assert property (cpu_type == cpu_type_strobe && !smm_cycle_indicator_n |=> smm_active)
      else $error("SMM strobe not latched.");
   chk_cpu_capture: assert property (!ads_in_n && !ads_oe |=> cpu_cycle_start && cpu_cycle_status == $past(status_in))
      else $error("CPU cycle not captured.");
endmodule : cycle_ctl_checker
bind local_bus_cycle_control cycle_ctl_checker chk_i (.*);
`default_nettype wire

// ==== testbench/cpu_side_model.sv ====
`default_nettype none
module cpu_side_model (
   input wire logic own, // High while this side may drive.
   input wire logic go, // Start a cycle.
   input wire logic [2:0] st, // Cycle status.
   input wire logic [1:0] ext, // Ready answers {burst, plain}.
   output logic ads_n, // Strobe.
   output logic [2:0] stat, // Status.
   output logic rdy_n, // Plain ready.
   output logic brdy_n // Burst ready.
);
   timeunit 1ns;
   timeprecision 100ps;
   assign ads_n = own ? !go : 1'bz;
   assign stat = own ? st : 3'bzzz;
   assign rdy_n = !ext[0];
   assign brdy_n = !ext[1];
endmodule : cpu_side_model
`default_nettype wire

// ==== testbench/local_bus_cycle_control_tb_top.sv ====
`default_nettype none
module local_bus_cycle_control_tb_top import cycle_ctl_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 0, reset = 1, hold_ack = 0, dma_bus_grant_in_n = 1, isa_master_n = 1, cpu_type = cpu_type_level;
   logic smm_cycle_indicator_n = 1, dram_hit = 0, slave_select = 0, burst_req = 0, alt_cycle_start = 0;
   logic alt_write = 0, alt_data = 0, alt_mem = 0, go = 0, p_ads, p_rdy, p_brdy;
   logic [1:0] ext = 0;
   logic [2:0] st = 0, p_st, status_out, cpu_cycle_status;
   logic [addr_w-1:0] cycle_addr = 0;
   logic [addr_w-1:0] nc_base [nc_regions] = '{32'h0000_1000, 32'h0000_8000};
   logic [addr_w-1:0] nc_limit [nc_regions] = '{32'h0000_1fff, 32'h0000_8fff};
   logic [nc_regions-1:0] nc_enable = 2'h3;
   logic ads_out_n, ads_oe, status_oe, rdy_out_n, rdy_oe, brdy_out_n, brdy_oe, cache_en_n, cpu_cycle_start;
   logic smm_active, cycle_ready, alt_is_isa, alt_busy;
   int err_total = 0, cmp_count = 0;
   wire ads_in_n = ads_oe ? ads_out_n : p_ads;
   wire [2:0] status_in = status_oe ? status_out : p_st;
   wire rdy_in_n = rdy_oe ? rdy_out_n : p_rdy;
   wire brdy_in_n = brdy_oe ? brdy_out_n : p_brdy;
   local_bus_cycle_control dut (.*);
   cpu_side_model far (.own(!ads_oe), .go(go), .st(st), .ext(ext), .ads_n(p_ads), .stat(p_st), .rdy_n(p_rdy),
      .brdy_n(p_brdy));
   always #12.5 mclk = ~mclk;
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   task automatic step(input int n = 1);
      repeat (n) @(posedge mclk);
      #2;
   endtask : step
   task automatic alt_cycle(input logic b, input logic isa);
      int n;
      {hold_ack, dma_bus_grant_in_n, isa_master_n, slave_select, burst_req} = {1'b1, 1'b0, !isa, 1'b1, b};
      {alt_cycle_start, alt_write, alt_data, alt_mem} = {1'b1, b, isa, !b};
      step();
      alt_cycle_start = 0;
      chk(ads_out_n === 1'b0 && status_oe === 1'b1 && alt_busy === 1'b1, "alt strobe");
      chk(status_out === {b, isa, !b} && alt_is_isa === isa && cpu_cycle_start === 1'b0, "alt status");
      n = 0;
      while ((b ? brdy_oe : rdy_oe) !== 1'b1 && n < 8) begin
         step();
         n++;
      end
      chk(n == 4 && (b ? brdy_out_n : rdy_out_n) === 1'b0 && (b ? rdy_oe : brdy_oe) === 1'b0, "alt ready");
      if (n == 8) tally_and_finish();
      step();
      chk(cycle_ready === 1'b1, "ready pulse");
   endtask : alt_cycle
   task automatic cpu_cycle(input logic [2:0] s, input logic eb);
      {hold_ack, slave_select, go, st} = {1'b0, 1'b0, 1'b1, s};
      step();
      go = 0;
      chk(ads_oe === 1'b0 && cpu_cycle_start === 1'b1 && cpu_cycle_status === s, "cpu capture");
      ext = {eb, !eb};
      step();
      ext = 0;
      chk(cycle_ready === 1'b1 && rdy_oe === 1'b0 && brdy_oe === 1'b0, "outside ready");
   endtask : cpu_cycle
   task automatic cpu_slave_cycle(input logic b);
      int n;
      {hold_ack, slave_select, burst_req, go, st} = {1'b0, 1'b1, b, 1'b1, 3'h2};
      step();
      go = 0;
      chk(ads_oe === 1'b0 && cpu_cycle_start === 1'b1, "slave taken");
      n = 0;
      while ((b ? brdy_oe : rdy_oe) !== 1'b1 && n < 8) begin
         step();
         n++;
      end
      chk(n == 3 && (b ? brdy_out_n : rdy_out_n) === 1'b0 && (b ? rdy_oe : brdy_oe) === 1'b0, "slave ready");
      if (n == 8) tally_and_finish();
      step();
      chk(cycle_ready === 1'b1 && rdy_oe === 1'b0 && brdy_oe === 1'b0, "slave ready pulse");
   endtask : cpu_slave_cycle
   task automatic cache_table();
      // Entries are {address, DRAM hit, window enables}, probing both edges of window 0 and the top edge of window 1.
      logic [34:0] v [7] = '{{32'h100, 3'h7}, {32'h100, 3'h3}, {32'h1000, 3'h7}, {32'h1fff, 3'h7},
         {32'h2000, 3'h7}, {32'h8fff, 3'h7}, {32'h1000, 3'h4}};
      logic [6:0] exp_off = 7'h2e;
      for (int i = 0; i < 7; i++) begin
         {cycle_addr, dram_hit, nc_enable} = v[i];
         step();
         chk(cache_en_n === exp_off[i], "cache enable");
      end
   endtask : cache_table
   task automatic smm_modes();
      smm_cycle_indicator_n = 0;
      step();
      chk(smm_active === 1'b1, "smm level on");
      smm_cycle_indicator_n = 1;
      step();
      chk(smm_active === 1'b0, "smm level off");
      {smm_cycle_indicator_n, cpu_type} = {1'b0, cpu_type_strobe};
      step();
      smm_cycle_indicator_n = 1;
      step(2);
      chk(smm_active === 1'b1, "smm strobe held");
      cpu_cycle(3'h5, 1'b0);
      chk(smm_active === 1'b0, "smm cleared");
   endtask : smm_modes
   initial begin
      step(3);
      chk(cache_en_n === 1'b1 && rdy_oe === 1'b0 && ads_out_n === 1'b1, "reset state");
      reset = 0;
      step();
      for (int i = 0; i < 4; i++) alt_cycle(i[0], i[1]);
      for (int i = 0; i < 2; i++) cpu_slave_cycle(i[0]);
      for (int i = 0; i < 8; i++) cpu_cycle(i[2:0], i[0]);
      cache_table();
      smm_modes();
      tally_and_finish();
   end
endmodule : local_bus_cycle_control_tb_top
`default_nettype wire
